/* File: tx_chain_pkg.sv */
package tx_chain_pkg;
  // apb register byte offsets
  localparam logic [11:0] OFS_CTRL      = 12'h0_000;
  localparam logic [11:0] OFS_CMD       = 12'h0_004;
  localparam logic [11:0] OFS_FIRST_TX  = 12'h0_008;
  localparam logic [11:0] OFS_STATUS    = 12'h0_00C;
  localparam logic [11:0] OFS_CUR_RX    = 12'h0_100;
  localparam logic [11:0] OFS_CUR_TX    = 12'h0_180;
  // ctrl fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_IFS_BIT   = 2;
  localparam int CTRL_FFE_BIT   = 3;
  localparam int CTRL_CTM_BIT   = 4;
  localparam int CTRL_LE_BIT    = 5;
  localparam int CTRL_PAT_LSB   = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0023;
  // modes
  localparam logic [1:0] MODE_TMA  = 2'h0;
  localparam logic [1:0] MODE_TMB  = 2'h1;
  localparam logic [1:0] MODE_RATE = 2'h2;
  localparam logic [1:0] MODE_HDLC = 2'h3;
  // commands in cmd register
  localparam int CMD_CODE_LSB = 5;
  localparam logic [2:0] CMD_INIT  = 3'h1;
  localparam logic [2:0] CMD_JUMP  = 3'h2;
  localparam logic [2:0] CMD_ABORT = 3'h3;
  // descriptor word 0 fields
  localparam int D_FE = 31;
  localparam int D_HOLD = 30;
  localparam int D_HI = 29;
  localparam int D_NO_LSB = 16;
  localparam int D_RA = 15;
  localparam int D_CSM = 11;
  localparam int D_FILL_COUNT_LSB = 0;
  // fill codes
  localparam logic [7:0] FILL_FLAG = 8'h7E;
  localparam logic [7:0] FILL_ONES = 8'hFF;
  localparam logic [7:0] FILL_ZERO = 8'h00;
  localparam logic [1:0] SYNC_FRAMES_LAST = 2'h2; // three frames
  localparam logic [1:0] LAST_DESC_WORD = 2'h2;
  localparam logic [1:0] NEXT_PTR_WORD = 2'h2;
  // timing
  localparam int POLL_CHAN_CLOCKS = 8;
endpackage : tx_chain_pkg

/* File: tx_descriptor_chain_engine.sv */
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module tx_descriptor_chain_engine #(
  parameter int NUM_CH = 32,
  parameter int NO_W   = 13,
  parameter int FILL_COUNT_W = 8
) (
  // clock and reset
  input  wire  logic                      pclk,
  input  wire  logic                      presetn,
  // apb slave
  input  wire  logic                      psel,
  input  wire  logic                      penable,
  input  wire  logic                      pwrite,
  input  wire  logic [11:0]               paddr,
  input  wire  logic [31:0]               pwdata,
  output logic                            pready,
  output logic [31:0]                     prdata,
  output logic                            pslverr,
  // shared memory read port
  output logic                            mem_rd_req,
  output logic [31:0]                     mem_addr,
  input  wire  logic                      mem_rd_ack,
  input  wire  logic [31:0]               mem_rdata,
  // byte stream to serial formatter
  output logic                            tx_valid,
  input  wire  logic                      tx_ready,
  input  wire  logic                      chan_clk_en,
  output logic [7:0]                      tx_byte,
  output logic                            tx_fill,
  output logic                            tx_frame_end,
  output logic                            tx_fcs,
  output logic                            tx_sync_err,
  // rate-adaptation status bits
  output logic                            ra_valid,
  output logic [9:0]                      ra_esx,
  // interrupt events
  output logic                            irq_valid,
  output logic [$clog2(NUM_CH)-1:0]       irq_chan,
  output logic                            irq_fi,
  output logic                            irq_fault,
  output logic                            irq_hi,
  // receive side branch reports
  input  wire  logic                      rx_branch,
  input  wire  logic [$clog2(NUM_CH)-1:0] rx_branch_chan,
  input  wire  logic [31:0]               rx_branch_addr
);
  localparam int CW = $clog2(NUM_CH);

  // refuse sizes that the field slices and counters cannot serve
  if (NUM_CH < 2 || NUM_CH > 32) begin : g_bad_ch
    $error("NUM_CH out of range");
  end
  if (NO_W > 13 || FILL_COUNT_W > 8 || FILL_COUNT_W < 2) begin : g_bad_w
    $error("field width out of range");
  end

  typedef enum logic [3:0] {
    ST_IDLE, ST_DESC, ST_CHECK, ST_RA, ST_WLOAD, ST_DATA,
    ST_END, ST_FILL, ST_BRANCH, ST_POLL_WAIT, ST_POLL_RD
  } eng_state_e;

  eng_state_e        state;
  logic [31:0]       ctrl;
  logic [31:0]       first_tx;
  logic [31:0]       cur_rx [NUM_CH];
  logic [31:0]       cur_tx [NUM_CH];
  logic [CW-1:0]     chan;
  logic              cmd_pend;
  logic [31:0]       desc_addr;
  logic [31:0]       d_ctrl;
  logic [31:0]       d_dptr;
  logic [31:0]       d_next;
  logic [1:0]        idx;
  logic [31:0]       word_addr;
  logic [31:0]       wbuf;
  logic [1:0]        bpos;
  logic [NO_W-1:0]   remain;
  logic [FILL_COUNT_W-1:0] fill_idx;
  logic [3:0]        poll_cnt;

  // apb decode
  wire        apb_wr    = psel & penable & pwrite;
  wire        apb_rd    = psel & penable & ~pwrite;
  wire        hit_ctrl  = (paddr == tx_chain_pkg::OFS_CTRL);
  wire        hit_cmd   = (paddr == tx_chain_pkg::OFS_CMD);
  wire        hit_first = (paddr == tx_chain_pkg::OFS_FIRST_TX);
  wire        hit_stat  = (paddr == tx_chain_pkg::OFS_STATUS);
  wire        hit_rx    = (paddr[11:7] == tx_chain_pkg::OFS_CUR_RX[11:7]) && (paddr[6:2] < NUM_CH);
  wire        hit_tx    = (paddr[11:7] == tx_chain_pkg::OFS_CUR_TX[11:7]) && (paddr[6:2] < NUM_CH);
  wire        hit_any   = hit_ctrl | hit_cmd | hit_first | hit_stat | hit_rx | hit_tx;
  wire [4:0]  arr_idx   = paddr[6:2];
  wire [2:0]  cmd_code  = pwdata[tx_chain_pkg::CMD_CODE_LSB +: 3];
  wire        cmd_go    = apb_wr & hit_cmd & ((cmd_code == tx_chain_pkg::CMD_INIT) |
                          (cmd_code == tx_chain_pkg::CMD_JUMP) | (cmd_code == tx_chain_pkg::CMD_ABORT));
  wire [31:0] status_w  = {16'h0000, 3'h0, cmd_pend, state, 3'h0, 5'(chan)};

  // zero-wait slave, error on unmapped address
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // configuration fields
  wire [1:0] mode      = ctrl[tx_chain_pkg::CTRL_MODE_LSB +: 2];
  wire       ifs       = ctrl[tx_chain_pkg::CTRL_IFS_BIT];
  wire       ffe       = ctrl[tx_chain_pkg::CTRL_FFE_BIT];
  wire       ctm       = ctrl[tx_chain_pkg::CTRL_CTM_BIT];
  wire       le        = ctrl[tx_chain_pkg::CTRL_LE_BIT];
  wire [7:0] pat       = ctrl[tx_chain_pkg::CTRL_PAT_LSB +: 8];
  wire       hdlc      = (mode == tx_chain_pkg::MODE_HDLC);
  wire       rate_mode = (mode == tx_chain_pkg::MODE_RATE);

  // descriptor fields
  wire              d_fe   = d_ctrl[tx_chain_pkg::D_FE];
  wire              d_hold = d_ctrl[tx_chain_pkg::D_HOLD];
  wire              d_hi   = d_ctrl[tx_chain_pkg::D_HI];
  wire              d_ra   = d_ctrl[tx_chain_pkg::D_RA];
  wire              d_csm  = d_ctrl[tx_chain_pkg::D_CSM];
  wire [NO_W-1:0]   d_no   = d_ctrl[tx_chain_pkg::D_NO_LSB +: NO_W];
  wire [FILL_COUNT_W-1:0] d_fill_count = d_ctrl[tx_chain_pkg::D_FILL_COUNT_LSB +: FILL_COUNT_W];

  // memory handshake and request address
  wire        mem_ok    = mem_rd_req & mem_rd_ack;
  wire        want_desc = (state == ST_DESC) | (state == ST_POLL_RD);
  wire        want_word = (state == ST_RA) | (state == ST_WLOAD);
  wire [31:0] want_addr = want_desc ? (desc_addr + {28'h000_0000, idx, 2'b00}) : word_addr;

  // byte selection: lane from offset and endianness
  wire [1:0] lane      = le ? bpos : ~bpos;
  wire [7:0] data_byte = wbuf[{lane, 3'b000} +: 8];
  wire [7:0] idle_byte = hdlc ? (ifs ? tx_chain_pkg::FILL_ONES : tx_chain_pkg::FILL_FLAG) :
                         (mode == tx_chain_pkg::MODE_TMA) ?
                         (ffe ? pat : tx_chain_pkg::FILL_ONES) : tx_chain_pkg::FILL_ZERO;
  wire       edge_pos  = (fill_idx == {FILL_COUNT_W{1'b0}}) | (fill_idx == d_fill_count);
  wire [7:0] hdlc_fill = (ifs & ~edge_pos) ? tx_chain_pkg::FILL_ONES : tx_chain_pkg::FILL_FLAG;
  wire [7:0] fill_byte = hdlc ? hdlc_fill : idle_byte;
  wire [FILL_COUNT_W-1:0] fill_last = rate_mode ? FILL_COUNT_W'(tx_chain_pkg::SYNC_FRAMES_LAST) : d_fill_count;
  wire       fcs_on    = hdlc & ~ctm & ~d_csm;
  wire       adv       = tx_valid & tx_ready;
  wire [31:0] branch_to = cmd_pend ? first_tx : d_next;

  // rate bits by endianness
  wire [9:0] esx_le = {mem_rdata[31:25], mem_rdata[24], mem_rdata[23], mem_rdata[22]};
  wire [9:0] esx_be = {mem_rdata[7:1], mem_rdata[0], mem_rdata[15], mem_rdata[14]};

  // apb register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= tx_chain_pkg::CTRL_RESET;
      first_tx <= 32'h0000_0000;
    end else begin
      if (apb_wr & hit_ctrl) ctrl <= pwdata;
      if (apb_wr & hit_first) first_tx <= pwdata;
    end
  end

  // apb read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= hit_ctrl  ? ctrl :
                hit_first ? first_tx :
                hit_stat  ? status_w :
                hit_rx    ? cur_rx[arr_idx] :
                hit_tx    ? cur_tx[arr_idx] : 32'h0000_0000;
    end
  end

  // current descriptor address table, one entry per channel
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_cur
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cur_rx[g] <= 32'h0000_0000;
          cur_tx[g] <= 32'h0000_0000;
        end else begin
          if (rx_branch && rx_branch_chan == CW'(g)) cur_rx[g] <= rx_branch_addr;
          if (state == ST_IDLE && cmd_go && pwdata[CW-1:0] == CW'(g)) begin
            cur_tx[g] <= first_tx;
          end else if (state == ST_BRANCH && chan == CW'(g)) begin
            cur_tx[g] <= branch_to;
          end
        end
      end
    end
  endgenerate

  // memory request, held until acknowledged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rd_req <= 1'b0;
      mem_addr   <= 32'h0000_0000;
    end else begin
      mem_rd_req <= (want_desc | want_word) & ~mem_ok;
      if (!mem_rd_req) mem_addr <= want_addr;
    end
  end

  // outgoing byte register, always loaded with fill when no data is due
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_byte      <= 8'h00;
      tx_fill      <= 1'b0;
      tx_frame_end <= 1'b0;
      tx_fcs       <= 1'b0;
      tx_sync_err  <= 1'b0;
    end else if (adv || !tx_valid) begin
      tx_frame_end <= (state == ST_DATA) && remain == NO_W'(1) && (d_fe | d_hold);
      tx_fcs       <= (state == ST_DATA) && remain == NO_W'(1) && (d_fe | d_hold) && fcs_on;
      tx_sync_err  <= (state == ST_FILL) && rate_mode;
      tx_fill      <= (state != ST_DATA);
      if (state == ST_DATA) begin
        tx_byte <= data_byte;
      end else if (state == ST_FILL) begin
        tx_byte <= fill_byte;
      end else begin
        tx_byte <= idle_byte;
      end
    end
  end

  // descriptor chain state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ST_IDLE;
      tx_valid  <= 1'b0;
      chan      <= '0;
      cmd_pend  <= 1'b0;
      desc_addr <= 32'h0000_0000;
      d_ctrl    <= 32'h0000_0000;
      d_dptr    <= 32'h0000_0000;
      d_next    <= 32'h0000_0000;
      idx       <= 2'h0;
      word_addr <= 32'h0000_0000;
      wbuf      <= 32'h0000_0000;
      bpos      <= 2'h0;
      remain    <= '0;
      fill_idx  <= '0;
      poll_cnt  <= 4'h0;
      ra_valid  <= 1'b0;
      ra_esx    <= 10'h000;
      irq_valid <= 1'b0;
      irq_chan  <= '0;
      irq_fi    <= 1'b0;
      irq_fault <= 1'b0;
      irq_hi    <= 1'b0;
    end else begin
      irq_valid <= 1'b0;
      ra_valid  <= 1'b0;
      if (cmd_go && state != ST_IDLE) cmd_pend <= 1'b1;
      case (state)
        ST_IDLE: begin
          if (cmd_go) begin
            chan      <= pwdata[CW-1:0];
            desc_addr <= first_tx;
            idx       <= 2'h0;
            tx_valid  <= 1'b1;
            state     <= ST_DESC;
          end
        end
        ST_DESC: begin
          if (mem_ok) begin
            if (idx == 2'h0) d_ctrl <= mem_rdata;
            if (idx == 2'h1) d_dptr <= mem_rdata;
            if (idx == tx_chain_pkg::LAST_DESC_WORD) begin
              d_next <= mem_rdata;
              state  <= ST_CHECK;
            end
            idx <= idx + 2'h1;
          end
        end
        ST_CHECK: begin
          word_addr <= {d_dptr[31:2], 2'b00};
          bpos      <= d_dptr[1:0];
          remain    <= d_no;
          irq_chan  <= chan;
          if (d_ra) begin
            state <= ST_RA;
          end else if (d_no == '0 && !d_fe) begin
            irq_valid <= 1'b1;
            irq_fi    <= 1'b0;
            irq_fault <= 1'b1;
            irq_hi    <= 1'b0;
            state     <= d_hold ? ST_END : ST_BRANCH;
          end else begin
            if (d_hold && (!d_fe || rate_mode)) begin
              irq_valid <= 1'b1;
              irq_fi    <= 1'b0;
              irq_fault <= 1'b1;
              irq_hi    <= 1'b0;
            end
            state <= (d_no == '0) ? ST_END : ST_WLOAD;
          end
        end
        ST_RA: begin
          if (mem_ok) begin
            ra_esx   <= le ? esx_le : esx_be;
            ra_valid <= 1'b1;
            state    <= ST_END;
          end
        end
        ST_WLOAD: begin
          if (mem_ok) begin
            wbuf  <= mem_rdata;
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (adv) begin
            remain <= remain - NO_W'(1);
            bpos   <= bpos + 2'h1;
            if (remain == NO_W'(1)) begin
              state <= ST_END;
            end else if (bpos == 2'h3) begin
              word_addr <= word_addr + 32'h0000_0004;
              state     <= ST_WLOAD;
            end
          end
        end
        ST_END: begin
          irq_chan  <= chan;
          irq_valid <= d_fe | d_hi;
          irq_fi    <= d_fe & ~rate_mode;
          irq_fault <= d_fe & rate_mode;
          irq_hi    <= d_hi;
          fill_idx  <= '0;
          state     <= (d_fe | d_hold) ? ST_FILL : ST_BRANCH;
        end
        ST_FILL: begin
          if (adv) begin
            fill_idx <= fill_idx + FILL_COUNT_W'(1);
            if (fill_idx == fill_last) begin
              poll_cnt <= 4'h0;
              state    <= d_hold ? ST_POLL_WAIT : ST_BRANCH;
            end
          end
        end
        ST_BRANCH: begin
          desc_addr <= branch_to;
          cmd_pend  <= cmd_go;
          idx       <= 2'h0;
          state     <= ST_DESC;
        end
        ST_POLL_WAIT: begin
          if (cmd_pend) begin
            state <= ST_BRANCH;
          end else if (chan_clk_en) begin
            poll_cnt <= poll_cnt + 4'h1;
            if (poll_cnt == 4'(tx_chain_pkg::POLL_CHAN_CLOCKS - 1)) begin
              idx   <= 2'h0;
              state <= ST_POLL_RD;
            end
          end
        end
        ST_POLL_RD: begin
          if (mem_ok) begin
            if (idx == 2'h0) begin
              d_ctrl <= mem_rdata;
              idx    <= tx_chain_pkg::NEXT_PTR_WORD;
            end else begin
              d_next   <= mem_rdata;
              poll_cnt <= 4'h0;
              state    <= (cmd_pend || !d_hold) ? ST_BRANCH : ST_POLL_WAIT;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule : tx_descriptor_chain_engine
`default_nettype wire

/* File: tx_chain_props.sv */
`timescale 1ns/10ps
`default_nettype none
module tx_chain_props (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // memory port
  input wire logic        mem_rd_req,
  input wire logic        mem_rd_ack,
  input wire logic [31:0] mem_addr,
  // byte stream
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_fill,
  input wire logic        tx_frame_end,
  input wire logic        tx_fcs,
  // events
  input wire logic        irq_valid,
  input wire logic        ra_valid
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // access phase and a stalled byte
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence
  AST_APB_READY: assert property (s_access |-> pready)
    else $error("pready low in access phase");
  AST_SLVERR_PHASE: assert property (pslverr |-> s_access)
    else $error("pslverr outside access phase");
  AST_REQ_HOLD: assert property (mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_addr))
    else $error("read request dropped or moved before ack");
  AST_REQ_DROP: assert property (mem_rd_req && mem_rd_ack |=> !mem_rd_req)
    else $error("read request held after ack");
  AST_BYTE_HOLD: assert property (s_stall |=> $stable(tx_byte) && $stable(tx_fill))
    else $error("byte changed while not taken");
  AST_FILL_FOREVER: assert property (tx_valid |=> tx_valid)
    else $error("stream stopped");
  AST_IRQ_PULSE: assert property (irq_valid |=> !irq_valid)
    else $error("interrupt event longer than one cycle");
  AST_END_IS_DATA: assert property (tx_valid && tx_frame_end |-> !tx_fill)
    else $error("frame end marked on a fill byte");
  AST_FCS_AT_END: assert property (tx_valid && tx_fcs |-> tx_frame_end)
    else $error("check sequence not at frame end");
  AST_RA_PULSE: assert property (ra_valid |=> !ra_valid)
    else $error("rate bits pulse too long");
endmodule : tx_chain_props
`default_nettype wire

/* File: shared_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module shared_mem_model (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // answer pace
  input wire logic        slow,
  // memory port
  input wire logic        mem_rd_req,
  input wire logic [31:0] mem_addr,
  output logic            mem_rd_ack,
  output logic [31:0]     mem_rdata
);
  logic [31:0] mem [0:255];
  logic [1:0]  wait_cnt;
  // one word per request, data line toggles when idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rd_ack <= 1'h0;
      wait_cnt   <= 2'h0;
      mem_rdata  <= 32'h0000_0000;
    end else if (mem_rd_req && !mem_rd_ack && (!slow || wait_cnt == 2'h3)) begin
      mem_rd_ack <= 1'h1;
      mem_rdata  <= mem[mem_addr[9:2]];
      wait_cnt   <= 2'h0;
    end else begin
      mem_rd_ack <= 1'h0;
      mem_rdata  <= ~mem_rdata;
      wait_cnt   <= mem_rd_req ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule : shared_mem_model
`default_nettype wire

/* File: tb_tx_descriptor_chain_engine.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_tx_descriptor_chain_engine;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, mem_addr, mem_rdata, rd;
  logic        pready, pslverr, mem_rd_req, mem_rd_ack, tx_valid, tx_fill, tx_frame_end;
  logic        tx_fcs, tx_sync_err, ra_valid, irq_valid, irq_fi, irq_fault, irq_hi, err;
  logic        tx_ready = 1'h0, chan_clk_en = 1'h0, slow = 1'h0, rx_branch = 1'h0;
  logic [4:0]  irq_chan, rx_branch_chan = 5'h00;
  logic [31:0] rx_branch_addr = 32'h0000_0000;
  logic [7:0]  tx_byte, cyc = 8'h00;
  logic [9:0]  ra_esx, ra_seen;
  logic [10:0] q[$], e[$];
  int          n_fail = 0, check_count = 0, n_data = 0, n_fi = 0, n_fault = 0, n_hi = 0;
  logic [31:0] ctrl_tab [6] = '{32'h0000_0023, 32'h0000_5A28, 32'h0000_0020, 32'h0000_0021,
                                32'h0000_0003, 32'h0000_0022};
  logic [10:0] fill_tab [5] = '{11'h17E, 11'h15A, 11'h1FF, 11'h100, 11'h17E};

  tx_descriptor_chain_engine i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mem_rd_req(mem_rd_req), .mem_addr(mem_addr), .mem_rd_ack(mem_rd_ack),
    .mem_rdata(mem_rdata), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .chan_clk_en(chan_clk_en), .tx_byte(tx_byte), .tx_fill(tx_fill),
    .tx_frame_end(tx_frame_end), .tx_fcs(tx_fcs), .tx_sync_err(tx_sync_err),
    .ra_valid(ra_valid), .ra_esx(ra_esx), .irq_valid(irq_valid), .irq_chan(irq_chan),
    .irq_fi(irq_fi), .irq_fault(irq_fault), .irq_hi(irq_hi), .rx_branch(rx_branch),
    .rx_branch_chan(rx_branch_chan), .rx_branch_addr(rx_branch_addr)
  );
  shared_mem_model i_mem (
    .pclk(pclk), .presetn(presetn), .slow(slow), .mem_rd_req(mem_rd_req),
    .mem_addr(mem_addr), .mem_rd_ack(mem_rd_ack), .mem_rdata(mem_rdata)
  );

  always #12.5 pclk = ~pclk;
  // sink stalls, channel clock strobes, memory pace
  always @(posedge pclk) begin
    cyc <= cyc + 8'h01;
    tx_ready <= cyc[1:0] == 2'h0;
    chan_clk_en <= cyc[0];
    slow <= cyc[7];
  end
  // log taken bytes and events
  always @(posedge pclk) begin
    if (tx_valid && tx_ready) begin
      q.push_back(tx_sync_err ? 11'h200 : {tx_fcs, 1'h0, tx_fill, tx_byte});
      n_data += !tx_fill && !tx_sync_err;
    end
    n_fi += irq_valid && irq_fi;
    n_fault += irq_valid && irq_fault;
    n_hi += irq_valid && irq_hi;
    if (ra_valid) ra_seen = ra_esx;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wait_cur(input logic [31:0] exp);
    apb(1'h0, tx_chain_pkg::OFS_CUR_TX + 12'h008, 32'h0000_0000);
    for (int i = 0; i < 1000 && rd !== exp; i++) apb(1'h0, tx_chain_pkg::OFS_CUR_TX + 12'h008, 32'h0);
    chk("cur_tx", rd, exp);
  endtask : wait_cur
  task automatic desc(input logic [31:0] a, input logic [31:0] w0, dp, nx);
    i_mem.mem[a[9:2]] = w0;
    i_mem.mem[a[9:2] + 8'h01] = dp;
    i_mem.mem[a[9:2] + 8'h02] = nx;
  endtask : desc
  // data bytes may follow idle fill, fill runs must match exactly
  task automatic check_stream;
    int i;
    i = 0;
    foreach (e[k]) begin
      if (!e[k][8] && !e[k][9]) while (i < q.size() && q[i][8]) i++;
      chk("stream", (i < q.size()) ? {21'h0, q[i]} : 32'hFFFF_FFFF, {21'h0, e[k]});
      i++;
    end
  endtask : check_stream
  task automatic finish_test;
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // watchdog
  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    finish_test();
  end
  // main sequence
  initial begin
    i_mem.mem[8'h80] = 32'h0302_01CC;
    i_mem.mem[8'h81] = 32'hDDDD_0504;
    i_mem.mem[8'h84] = 32'h0706_05CC;
    i_mem.mem[8'h88] = 32'hA640_0000;
    desc(32'h0000_0100, 32'h8005_0002, 32'h0000_0201, 32'h0000_0140);
    desc(32'h0000_0140, 32'hA001_0800, 32'h0000_0212, 32'h0000_0180);
    desc(32'h0000_0180, 32'hC001_0000, 32'h0000_0213, 32'h0000_0100);
    desc(32'h0000_01C0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0180);
    desc(32'h0000_0300, 32'h8001_0800, 32'h0000_0212, 32'h0000_03C0);
    desc(32'h0000_0340, 32'h0002_8000, 32'h0000_0220, 32'h0000_0300);
    desc(32'h0000_03C0, 32'hC001_0000, 32'h0000_0211, 32'h0000_03C0);
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, tx_chain_pkg::OFS_CTRL, 32'h0000_0000);
    chk("ctrl", rd, tx_chain_pkg::CTRL_RESET);
    apb(1'h0, tx_chain_pkg::OFS_CUR_TX + 12'h014, 32'h0000_0000);
    chk("cur_tx5", rd, 32'h0000_0000);
    apb(1'h0, 12'h010, 32'h0000_0000);
    chk("slverr", {31'h0, err}, 32'h0000_0001);
    // receive side branch report
    @(posedge pclk);
    rx_branch <= 1'h1;
    rx_branch_chan <= 5'h03;
    rx_branch_addr <= 32'h1234_5670;
    @(posedge pclk);
    rx_branch <= 1'h0;
    apb(1'h0, tx_chain_pkg::OFS_CUR_RX + 12'h00C, 32'h0000_0000);
    chk("cur_rx3", rd, 32'h1234_5670);
    // hdlc chain, hold, jump, release
    apb(1'h1, tx_chain_pkg::OFS_CTRL, 32'h0000_0027);
    apb(1'h1, tx_chain_pkg::OFS_FIRST_TX, 32'h0000_0100);
    apb(1'h1, tx_chain_pkg::OFS_CMD, {24'h00_0000, tx_chain_pkg::CMD_INIT, 5'h02});
    wait_cur(32'h0000_0180);
    apb(1'h1, tx_chain_pkg::OFS_FIRST_TX, 32'h0000_01C0);
    apb(1'h1, tx_chain_pkg::OFS_CMD, {24'h00_0000, tx_chain_pkg::CMD_JUMP, 5'h02});
    repeat (4000) if (n_fault == 0) @(posedge pclk);
    chk("fault", 32'(n_fault), 32'h0000_0001);
    i_mem.mem[8'h62] = 32'h0000_03C0;
    i_mem.mem[8'h60] = 32'h8001_0000;
    wait_cur(32'h0000_03C0);
    repeat (4000) if (n_data < 9) @(posedge pclk);
    e = '{11'h001, 11'h002, 11'h003, 11'h004, 11'h405, 11'h17E, 11'h1FF, 11'h17E,
          11'h006, 11'h17E, 11'h407, 11'h407, 11'h405};
    check_stream();
    chk("hi", 32'(n_hi), 32'h0000_0001);
    chk("fi", 32'(n_fi >= 3), 32'h0000_0001);
    // each mode, each branching command, big endian lanes in pass 4
    for (int k = 0; k < 6; k++) begin
      apb(1'h1, tx_chain_pkg::OFS_CTRL, ctrl_tab[k]);
      apb(1'h1, tx_chain_pkg::OFS_FIRST_TX, (k == 5) ? 32'h0000_0340 : 32'h0000_0300);
      q.delete();
      n_data = 0;
      apb(1'h1, tx_chain_pkg::OFS_CMD, {24'h00_0000, 3'(k % 3 + 1), 5'h02});
      repeat (4000) if (n_data < 2) @(posedge pclk);
      e = {(k == 4) ? 11'h005 : 11'h006};
      if (k == 5) e = {e, 11'h200, 11'h200, 11'h200};
      else e.push_back(fill_tab[k]);
      e.push_back((k == 0) ? 11'h405 : (k == 4) ? 11'h406 : 11'h005);
      check_stream();
    end
    chk("ra_esx", {22'h0, ra_seen}, 32'h0000_0299);
    chk("irq_chan", {27'h0, irq_chan}, 32'h0000_0002);
    finish_test();
  end
endmodule : tb_tx_descriptor_chain_engine

bind tx_descriptor_chain_engine tx_chain_props i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .mem_rd_req(mem_rd_req), .mem_rd_ack(mem_rd_ack),
  .mem_addr(mem_addr), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
  .tx_fill(tx_fill), .tx_frame_end(tx_frame_end), .tx_fcs(tx_fcs),
  .irq_valid(irq_valid), .ra_valid(ra_valid)
);
`default_nettype wire
